// ### owatc_checker.sv
// concurrent checks on the ports of the transmit controller
`timescale 1ns/1ps
module owatc_checker #(
  parameter int ON_DELAY_CYCLES = 1,
  parameter int ACK_CYCLES = 1,
  parameter int ERR_CYCLES = 1,
  parameter int IDLE_HIGH_CYCLES = 1,
  parameter int LOW_TIMEOUT_CYCLES = 1,
  parameter int HALF_PERIOD_CYCLES = 1,
  parameter int OFF_DELAY_HALVES = 1
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic SINGLE_WIRE_LINE_IN,
  input wire logic SINGLE_WIRE_LINE_OUT,
  input wire logic SINGLE_WIRE_LINE_OE_N,
  input wire logic ANTENNA_DRIVE_OUT,
  input wire logic STANDBY,
  input wire logic FAULT_SEEN
);
  wire ln = SINGLE_WIRE_LINE_IN;
  wire oe_n = SINGLE_WIRE_LINE_OE_N;
  wire drv = ANTENNA_DRIVE_OUT;
  int low_run, hi_run, drv_hi, drv_lo, oe_lo;
  logic rpt_flt;
  ////////////////////////////////////////////////////////////////
  // run lengths; low_run counts only lows not made by the controller
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      low_run <= 0;
      hi_run <= 0;
      drv_hi <= 0;
      drv_lo <= 0;
      oe_lo <= 0;
      rpt_flt <= 1'b0;
    end else begin
      low_run <= (!ln && oe_n) ? low_run + 1 : 0;
      hi_run <= ln ? hi_run + 1 : 0;
      drv_hi <= drv ? drv_hi + 1 : 0;
      drv_lo <= drv ? 0 : drv_lo + 1;
      oe_lo <= oe_n ? 0 : oe_lo + 1;
      rpt_flt <= oe_n ? FAULT_SEEN : rpt_flt;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);
  sequence s_wake;
    $fell(ln) && STANDBY;
  endsequence
  sequence s_new_burst;
    $rose(drv) && drv_lo > 2 * HALF_PERIOD_CYCLES;
  endsequence
  a_line_data_low: assert property (SINGLE_WIRE_LINE_OUT == 1'b0)
    else $error("line data bit not low");
  a_standby_quiet: assert property (STANDBY [*4] |-> !drv && oe_n)
    else $error("activity in standby");
  a_wake_on_low: assert property (s_wake |-> ##[0:4] !STANDBY)
    else $error("no wake after line low");
  a_on_delay_held: assert property (s_new_burst |-> low_run >= ON_DELAY_CYCLES)
    else $error("drive started early");
  a_drive_starts: assert property (low_run == ON_DELAY_CYCLES + 6 |-> drv_lo <= 8)
    else $error("drive not started");
  a_half_wave: assert property (drv |-> drv_hi < HALF_PERIOD_CYCLES)
    else $error("drive high too long");
  a_off_delay_end: assert property (
    hi_run > (OFF_DELAY_HALVES + 1) * HALF_PERIOD_CYCLES + 4 |-> !drv)
    else $error("drive not stopped");
  a_low_timeout_off: assert property (
    low_run inside {[LOW_TIMEOUT_CYCLES + 6:LOW_TIMEOUT_CYCLES + ON_DELAY_CYCLES]}
    |-> !drv)
    else $error("drive on after low timeout");
  a_report_length: assert property (
    $rose(oe_n) |-> oe_lo == (rpt_flt ? ERR_CYCLES + 1 : ACK_CYCLES + 1))
    else $error("report pulse length wrong");
  a_report_idle: assert property ($fell(oe_n) |-> hi_run >= IDLE_HIGH_CYCLES)
    else $error("report before idle timeout");
endmodule

bind owatc_top owatc_checker #(
  .ON_DELAY_CYCLES(ON_DELAY_CYCLES),
  .ACK_CYCLES(ACK_CYCLES),
  .ERR_CYCLES(ERR_CYCLES),
  .IDLE_HIGH_CYCLES(IDLE_HIGH_CYCLES),
  .LOW_TIMEOUT_CYCLES(LOW_TIMEOUT_CYCLES),
  .HALF_PERIOD_CYCLES(HALF_PERIOD_CYCLES),
  .OFF_DELAY_HALVES(OFF_DELAY_HALVES)
) u_chk (
  .MCLK(MCLK),
  .RST_N(RST_N),
  .SINGLE_WIRE_LINE_IN(SINGLE_WIRE_LINE_IN),
  .SINGLE_WIRE_LINE_OUT(SINGLE_WIRE_LINE_OUT),
  .SINGLE_WIRE_LINE_OE_N(SINGLE_WIRE_LINE_OE_N),
  .ANTENNA_DRIVE_OUT(ANTENNA_DRIVE_OUT),
  .STANDBY(STANDBY),
  .FAULT_SEEN(FAULT_SEEN)
);

// ### owatc_pkg.sv
// constants and state type for the one-wire ASK transmit controller
package owatc_pkg;

  // clock of the tracking oscillator model
  localparam int CLK_MHZ = 200;

  // width of every interval counter
  localparam int CNT_W = 24;

  // on-delay after the line goes low
  localparam int ON_DELAY_US = 64;
  localparam int ON_DELAY_CYC = ON_DELAY_US * CLK_MHZ;

  // acknowledge pulse length
  localparam int ACK_US = 256;
  localparam int ACK_CYC = ACK_US * CLK_MHZ;

  // error pulse length
  localparam int ERR_US = 128;
  localparam int ERR_CYC = ERR_US * CLK_MHZ;

  // idle-high timeout ending a sequence
  localparam int IDLE_HIGH_MS = 16;
  localparam int IDLE_HIGH_CYC = IDLE_HIGH_MS * 1000 * CLK_MHZ;

  // stuck-low timeout
  localparam int LOW_TIMEOUT_MS = 20;
  localparam int LOW_TIMEOUT_CYC = LOW_TIMEOUT_MS * 1000 * CLK_MHZ;

  // antenna resonance and half period of the drive square wave
  localparam int RES_KHZ = 125;
  localparam int HALF_PERIOD_CYC = (CLK_MHZ * 1000) / (2 * RES_KHZ);

  // off-delay counted in drive half periods
  localparam int OFF_DELAY_HALVES = 8;

  // reset values of the outputs and of the phase and armed flags
  localparam logic RST_DRIVE = 1'b0;
  localparam logic RST_LINE_OE_N = 1'b1;
  localparam logic RST_LINE_OUT = 1'b0;
  localparam logic RST_STANDBY = 1'b1;
  localparam logic RST_FAULT = 1'b0;
  localparam logic RST_KLINE = 1'b0;
  localparam logic RST_PHASE = 1'b1;
  localparam logic RST_ARMED = 1'b1;

  // controller states
  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_TRANSMIT = 2'b01,
    ST_REPORT = 2'b10
  } owatc_state_t;

endpackage

// ### owatc_timer.sv
// saturating interval counter with clear and run
`timescale 1ns/1ps
module owatc_timer #(
  parameter int WIDTH = 24
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic run,
  input wire logic [WIDTH-1:0] limit,
  output logic done
);

  logic [WIDTH-1:0] count;

  // clear wins over run, count holds at the limit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (run && !done) begin
      count <= count + 1'b1;
    end
  end

  assign done = (count >= limit);

endmodule

// ### owatc_top.sv
// one-wire ASK antenna transmit controller
`timescale 1ns/1ps

// What this block does
// - after reset, line high: stay in standby
// - standby keeps only the line receiver and the level-select report active
// - line high means interface level, low ground
// - line pulled low wakes into transmission
// - line low in transmission: resonant square wave
// - line high in transmission: drive held low
// - drive on after line low for on-delay
// - drive off after line high for off-delay
// - off-delay counted in resonance half periods
// - low timeout counter runs while line low
// - low timeout: drive off, back to standby
// - idle-high timeout: report pulse, then standby
// - no fault: acknowledge pulse of 256 us
// - fault seen: error pulse of 128 us
// - all logic clocked by the tracking oscillator
module owatc_top #(
  parameter int ON_DELAY_CYCLES = owatc_pkg::ON_DELAY_CYC,
  parameter int ACK_CYCLES = owatc_pkg::ACK_CYC,
  parameter int ERR_CYCLES = owatc_pkg::ERR_CYC,
  parameter int IDLE_HIGH_CYCLES = owatc_pkg::IDLE_HIGH_CYC,
  parameter int LOW_TIMEOUT_CYCLES = owatc_pkg::LOW_TIMEOUT_CYC,
  parameter int HALF_PERIOD_CYCLES = owatc_pkg::HALF_PERIOD_CYC,
  parameter int OFF_DELAY_HALVES = owatc_pkg::OFF_DELAY_HALVES
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic SINGLE_WIRE_LINE_IN,
  output logic SINGLE_WIRE_LINE_OUT,
  output logic SINGLE_WIRE_LINE_OE_N,
  input wire logic LINE_LEVEL_SELECT,
  input wire logic FAULT_DETECT,
  output logic ANTENNA_DRIVE_OUT,
  output logic STANDBY,
  output logic FAULT_SEEN,
  output logic KLINE_MODE
);

  import owatc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  localparam logic [CNT_W-1:0] ON_LIMIT = CNT_W'(ON_DELAY_CYCLES);
  localparam logic [CNT_W-1:0] ACK_LIMIT = CNT_W'(ACK_CYCLES);
  localparam logic [CNT_W-1:0] ERR_LIMIT = CNT_W'(ERR_CYCLES);
  localparam logic [CNT_W-1:0] IDLE_LIMIT = CNT_W'(IDLE_HIGH_CYCLES);
  localparam logic [CNT_W-1:0] LOW_LIMIT = CNT_W'(LOW_TIMEOUT_CYCLES);
  localparam logic [CNT_W-1:0] OFF_LIMIT = CNT_W'(OFF_DELAY_HALVES);
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_PERIOD_CYCLES - 1);

  owatc_state_t state;
  owatc_state_t next_state;

  logic line_meta;
  logic line_s;
  logic fault_meta;
  logic fault_s;
  logic level_meta;
  logic level_s;

  logic line_low;
  logic in_tx;
  logic in_report;
  logic armed;
  logic drive_on;
  logic fault;
  logic phase;
  logic half_tick;
  logic [CNT_W-1:0] half_cnt;
  logic [CNT_W-1:0] report_limit;

  logic on_done;
  logic off_done;
  logic low_done;
  logic idle_done;
  logic report_done;

  logic next_drive;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  // two stages on the wire and the side inputs
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      line_meta <= 1'b1;
      line_s <= 1'b1;
    end else begin
      line_meta <= SINGLE_WIRE_LINE_IN;
      line_s <= line_meta;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      fault_meta <= 1'b0;
      fault_s <= 1'b0;
    end else begin
      fault_meta <= FAULT_DETECT;
      fault_s <= fault_meta;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      level_meta <= 1'b0;
      level_s <= 1'b0;
    end else begin
      level_meta <= LINE_LEVEL_SELECT;
      level_s <= level_meta;
    end
  end

  // logic low is ground, high is the selected interface level
  assign line_low = ~line_s;
  assign in_tx = (state == ST_TRANSMIT);
  assign in_report = (state == ST_REPORT);

  ////////////////////////////////////////////////////////////////////////////
  // controller state machine

  always_comb begin
    next_state = state;
    case (state)
      ST_STANDBY: begin
        if (armed && line_low) begin
          next_state = ST_TRANSMIT;
        end
      end
      ST_TRANSMIT: begin
        if (low_done) begin
          next_state = ST_STANDBY;
        end else if (idle_done) begin
          next_state = ST_REPORT;
        end
      end
      ST_REPORT: begin
        if (report_done) begin
          next_state = ST_STANDBY;
        end
      end
      default: begin
        next_state = ST_STANDBY;
      end
    endcase
  end

  // reset lands in standby and waits for the line
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      state <= ST_STANDBY;
    end else begin
      state <= next_state;
    end
  end

  // after a report or a low timeout, wait for the line to rise before waking
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      armed <= RST_ARMED;
    end else if (in_report || (in_tx && low_done)) begin
      armed <= 1'b0;
    end else if (line_s) begin
      armed <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // debounce and timeout counters, all held clear in standby

  owatc_timer #(
    .WIDTH(CNT_W)
  ) u_on_delay (
    .clk(MCLK),
    .rst_n(RST_N),
    .clear(!in_tx || line_s || drive_on),
    .run(line_low),
    .limit(ON_LIMIT),
    .done(on_done)
  );

  owatc_timer #(
    .WIDTH(CNT_W)
  ) u_off_delay (
    .clk(MCLK),
    .rst_n(RST_N),
    .clear(!in_tx || line_low || !drive_on),
    .run(half_tick),
    .limit(OFF_LIMIT),
    .done(off_done)
  );

  owatc_timer #(
    .WIDTH(CNT_W)
  ) u_low_timeout (
    .clk(MCLK),
    .rst_n(RST_N),
    .clear(!in_tx || line_s),
    .run(line_low),
    .limit(LOW_LIMIT),
    .done(low_done)
  );

  owatc_timer #(
    .WIDTH(CNT_W)
  ) u_idle_high (
    .clk(MCLK),
    .rst_n(RST_N),
    .clear(!in_tx || line_low),
    .run(1'b1),
    .limit(IDLE_LIMIT),
    .done(idle_done)
  );

  // report length chosen by the fault latch
  assign report_limit = fault ? ERR_LIMIT : ACK_LIMIT;

  owatc_timer #(
    .WIDTH(CNT_W)
  ) u_report (
    .clk(MCLK),
    .rst_n(RST_N),
    .clear(!in_report),
    .run(1'b1),
    .limit(report_limit),
    .done(report_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // drive enable with debounce on both edges

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      drive_on <= 1'b0;
    end else if (!in_tx || low_done) begin
      drive_on <= 1'b0;
    end else if (off_done) begin
      drive_on <= 1'b0;
    end else if (on_done) begin
      drive_on <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // resonant square wave

  // half period divider; also times the off-delay
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      half_cnt <= '0;
      half_tick <= 1'b0;
      phase <= RST_PHASE;
    end else if (!drive_on) begin
      half_cnt <= '0;
      half_tick <= 1'b0;
      phase <= RST_PHASE;
    end else if (half_cnt == HALF_LAST) begin
      half_cnt <= '0;
      half_tick <= 1'b1;
      phase <= ~phase;
    end else begin
      half_cnt <= half_cnt + 1'b1;
      half_tick <= 1'b0;
    end
  end

  // gated wave; ground whenever the drive is off
  assign next_drive = drive_on && phase;

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ANTENNA_DRIVE_OUT <= RST_DRIVE;
    end else begin
      ANTENNA_DRIVE_OUT <= next_drive;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault latch, cleared only in standby

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      fault <= 1'b0;
    end else if (state == ST_STANDBY) begin
      fault <= 1'b0;
    end else if (in_tx && fault_s) begin
      fault <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line driver and status outputs

  // open-drain: pull low for the whole report phase
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      SINGLE_WIRE_LINE_OE_N <= RST_LINE_OE_N;
      SINGLE_WIRE_LINE_OUT <= RST_LINE_OUT;
    end else begin
      SINGLE_WIRE_LINE_OE_N <= ~(next_state == ST_REPORT);
      SINGLE_WIRE_LINE_OUT <= RST_LINE_OUT;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      STANDBY <= RST_STANDBY;
    end else begin
      STANDBY <= (next_state == ST_STANDBY);
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      FAULT_SEEN <= RST_FAULT;
    end else begin
      FAULT_SEEN <= fault;
    end
  end

  // level selection only reported; the pad handles the voltage
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      KLINE_MODE <= RST_KLINE;
    end else begin
      KLINE_MODE <= level_s;
    end
  end

endmodule

// ### owatc_wire_model.sv
// controller side of the single wire, with pull-up
`timescale 1ns/1ps
module owatc_wire_model (
  input wire logic pull_low,
  input wire logic dev_oe_n,
  output logic line
);
  // pull-up wins unless either party pulls low
  assign line = !(pull_low || !dev_oe_n);
endmodule

// ### tb_top.sv
// self-checking bench for the transmit controller
`timescale 1ns/1ps
module tb_top;
  localparam int ON = 20, ACK = 40, ERR = 20, IDLE = 200, LOW = 300, HALF = 4, OFF = 3;
  logic mclk, rst_n, pull_low, lls, fault, line, l_out, oe_n, drv, stby, fseen, kline;
  int num_errors, checked, n, k;
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  owatc_top #(.ON_DELAY_CYCLES(ON), .ACK_CYCLES(ACK), .ERR_CYCLES(ERR),
    .IDLE_HIGH_CYCLES(IDLE), .LOW_TIMEOUT_CYCLES(LOW), .HALF_PERIOD_CYCLES(HALF),
    .OFF_DELAY_HALVES(OFF)) dut (
    .MCLK(mclk),
    .RST_N(rst_n),
    .SINGLE_WIRE_LINE_IN(line),
    .SINGLE_WIRE_LINE_OUT(l_out),
    .SINGLE_WIRE_LINE_OE_N(oe_n),
    .LINE_LEVEL_SELECT(lls),
    .FAULT_DETECT(fault),
    .ANTENNA_DRIVE_OUT(drv),
    .STANDBY(stby),
    .FAULT_SEEN(fseen),
    .KLINE_MODE(kline)
  );
  owatc_wire_model u_wire (.pull_low(pull_low), .dev_oe_n(oe_n), .line(line));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask
  task automatic finish_test;
    if (num_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // bounded wait for drive (sel 0) or output enable (sel 1)
  task automatic wait_on(input bit sel, input logic v, input int lim, output int c);
    c = 0;
    while ((sel ? oe_n : drv) !== v) begin
      step(1);
      c++;
      if (c > lim) begin
        num_errors++;
        finish_test();
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_ask;
    pull_low = 1'b1;
    step(4);
    chk("standby after wake", stby, 1'b0);
    wait_on(0, 1'b1, ON + 10, n);
    chk("on delay kept", n + 4 >= ON, 1'b1);
    wait_on(0, 1'b0, HALF + 2, n);
    chk("high half", n, HALF);
    wait_on(0, 1'b1, HALF + 2, n);
    chk("low half", n, HALF);
    pull_low = 1'b0;
    k = 0;
    repeat (2 * HALF) begin
      step(1);
      k += (drv === 1'b1);
    end
    chk("short high filtered", k > 0, 1'b1);
    step((OFF + 1) * HALF);
    repeat (2 * HALF) begin
      step(1);
      chk("drive off", drv, 1'b0);
    end
    wait_on(1, 1'b0, IDLE + 20, n);
    wait_on(1, 1'b1, ACK + 5, n);
    chk("ack length", n, ACK + 1);
    chk("standby after ack", stby, 1'b1);
  endtask
  task automatic t_fault;
    step(5);
    pull_low = 1'b1;
    step(4);
    fault = 1'b1;
    step(4);
    chk("fault latched", fseen, 1'b1);
    fault = 1'b0;
    pull_low = 1'b0;
    wait_on(1, 1'b0, IDLE + 20, n);
    wait_on(1, 1'b1, ERR + 5, n);
    chk("error length", n, ERR + 1);
    step(2);
    chk("fault cleared", fseen, 1'b0);
  endtask
  task automatic t_timeout;
    step(5);
    pull_low = 1'b1;
    repeat (3) begin
      step(LOW - 50);
      pull_low = 1'b0;
      step(1);
      pull_low = 1'b1;
    end
    chk("kept awake", stby, 1'b0);
    k = 0;
    repeat (2 * HALF) begin
      step(1);
      k += (drv === 1'b1);
    end
    chk("still driving", k, HALF);
    step(LOW + 10);
    chk("drive after timeout", drv, 1'b0);
    pull_low = 1'b0;
    step(IDLE + 20);
    chk("no report", oe_n, 1'b1);
    chk("standby after timeout", stby, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    pull_low = 1'b0;
    lls = 1'b0;
    fault = 1'b0;
    num_errors = 0;
    checked = 0;
    step(4);
    rst_n = 1'b1;
    step(1);
    chk("standby at start", stby, 1'b1);
    chk("drive at start", drv, 1'b0);
    chk("oe_n at start", oe_n, 1'b1);
    t_ask();
    t_fault();
    t_timeout();
    lls = 1'b1;
    step(5);
    chk("level select", kline, 1'b1);
    finish_test();
  end
endmodule
